// File: hw/csd_status_diag.sv
// Node state, interrupt code, error counters and last error diagnosis
// of a CAN controller, read over AXI4-Lite.
// Assumes the bit stream engine reports fields, bits and errors on the
// same clock, and a transceiver sits on the bus pins.
`timescale 1ns/1ps

`include "csd_defs.svh"

module csd_status_diag #(
  parameter int NUM_BUF = 15,
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // AXI4-Lite slave.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controller core.
  input wire logic can_enable,
  input wire logic [NUM_BUF-1:0] buffer_pending_flags,
  input wire csd_pkg::csd_fc_ev_t fc_ev,
  input wire csd_pkg::csd_err_ev_t err_ev,
  input wire csd_pkg::csd_field_t field_in,
  input wire logic transmitting,
  input wire logic ack_slot,
  input wire logic active_err_flag,
  input wire logic tx_bit,
  // Bus pins.
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin
);
  import csd_pkg::*;

  // ========================================================
  // Parameter checks.
  initial begin
    if (NUM_BUF < 1 || NUM_BUF > 15 || ADDR_W < 5 || ADDR_W > 8) begin
      $error("csd_status_diag: unsupported parameter values.");
    end
  end

  // ========================================================
  // Priority encoder of the interrupt code.
  function automatic logic [4:0] irq_code(input logic [15:0] act);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 14; i >= 0; i--) begin
      if (act[i]) begin
        c = {1'b1, 4'(i + 1)};
      end
    end
    if (act[`CSD_MASK_ERR_BIT]) begin
      c = 5'h10;
    end
    return c;
  endfunction : irq_code

  // ========================================================
  // Node state from counters.
  function automatic logic [2:0] node_state(input logic en,
      input logic boff, input logic [7:0] receive_fault_count, input logic [7:0] transmit_fault_count);
    logic [2:0] n;
    if (!en) begin
      n = CSD_NS_OFF;
    end else if (boff) begin
      n = CSD_NS_BUSOFF;
    end else if (receive_fault_count >= `CSD_PASSIVE_LIMIT ||
        transmit_fault_count >= `CSD_PASSIVE_LIMIT) begin
      n = CSD_NS_PASSIVE;
    end else if (receive_fault_count >= `CSD_WARN_LIMIT || transmit_fault_count >= `CSD_WARN_LIMIT) begin
      n = CSD_NS_WARN;
    end else begin
      n = CSD_NS_ACTIVE;
    end
    return n;
  endfunction : node_state

  csd_state_t s_q;
  csd_state_t s_d;
  logic [14:0] buf_pend;
  logic [15:0] pend;
  logic [15:0] status_w;
  logic [15:0] count_w;
  logic [15:0] pend_w;

  // ========================================================
  // Read views.
  always_comb begin
    buf_pend = 15'h0000;
    buf_pend[NUM_BUF-1:0] = buffer_pending_flags;
    pend = {s_q.fault_pend, buf_pend};
    status_w = {8'h00, s_q.ns, irq_code(pend & s_q.mask)};
    count_w = {s_q.receive_fault_count, s_q.transmit_fault_count};
    pend_w = pend;
  end

  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign bus_transmit_pin = s_q.tx_pin;

  // ========================================================
  // Next state.
  always_comb begin
    logic [8:0] rec_n;
    logic [8:0] tec_n;
    logic boff_n;
    logic have_aw;
    logic have_w;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [7:0] ra;
    logic clr;
    logic chg;
    rec_n = {1'b0, s_q.receive_fault_count};
    tec_n = {1'b0, s_q.transmit_fault_count};
    boff_n = s_q.bus_off;
    have_aw = 1'b0;
    have_w = 1'b0;
    wa = 8'h00;
    wd = 32'h0000_0000;
    ws = 4'h0;
    ra = 8'h00;
    clr = 1'b0;
    chg = 1'b0;
    s_d = s_q;

    // Receive pin synchroniser.
    s_d.rx_s1 = bus_receive_pin;
    s_d.rx_s2 = s_q.rx_s1;

    // Transmit pin: a receiver drives only in ack and error flag.
    if (transmitting || ack_slot || active_err_flag) begin
      s_d.tx_pin = tx_bit;
    end else begin
      s_d.tx_pin = `CSD_RST_PIN;
    end

    // Fault confinement counters.
    if (fc_ev.recover) begin
      rec_n = 9'h000;
      tec_n = 9'h000;
      boff_n = 1'b0;
    end else if (!s_q.bus_off) begin
      if (fc_ev.rx_err_heavy) begin
        rec_n = rec_n + `CSD_STEP_HEAVY;
      end else if (fc_ev.rx_err) begin
        rec_n = rec_n + `CSD_STEP_LIGHT;
      end else if (fc_ev.rx_ok) begin
        if (s_q.receive_fault_count > `CSD_REC_CAP) begin
          rec_n = {1'b0, `CSD_REC_CAP};
        end else if (s_q.receive_fault_count != 8'h00) begin
          rec_n = rec_n - `CSD_STEP_LIGHT;
        end
      end
      if (rec_n > `CSD_CNT_MAX) begin
        rec_n = `CSD_CNT_MAX;
      end
      if (fc_ev.tx_err) begin
        tec_n = tec_n + `CSD_STEP_HEAVY;
      end else if (fc_ev.tx_ok && s_q.transmit_fault_count != 8'h00) begin
        tec_n = tec_n - `CSD_STEP_LIGHT;
      end
      if (tec_n > `CSD_CNT_MAX) begin
        tec_n = `CSD_CNT_MAX;
        boff_n = 1'b1;
      end
    end
    s_d.receive_fault_count = rec_n[7:0];
    s_d.transmit_fault_count = tec_n[7:0];
    s_d.bus_off = boff_n;
    s_d.ns = node_state(can_enable, boff_n, rec_n[7:0],
        tec_n[7:0]);
    chg = (rec_n[7:0] != s_q.receive_fault_count) || (tec_n[7:0] != s_q.transmit_fault_count) ||
        (boff_n != s_q.bus_off);

    // Field tracking and bit index.
    if (field_in.field_start) begin
      s_d.field = field_in.field_code;
      s_d.bit_cnt = 6'(field_in.field_len - 7'h01);
    end else if (field_in.bit_tick) begin
      s_d.bit_cnt = s_q.bit_cnt - 6'h01;
    end

    // Capture of the last bus error.
    if (err_ev.error) begin
      s_d.diag.rsvd = 1'b0;
      s_d.diag.drive = s_q.tx_pin;
      s_d.diag.mon = s_q.rx_s2;
      s_d.diag.crc = err_ev.crc;
      s_d.diag.stuff = err_ev.stuff;
      s_d.diag.was_transmitter_flag = transmitting;
      s_d.diag.bit_index = s_q.bit_cnt;
      s_d.diag.field = s_q.field;
    end

    // Write channel: address and data in either order.
    have_aw = s_q.aw_got || (s_axi_awvalid && s_axi_awready);
    have_w = s_q.w_got || (s_axi_wvalid && s_axi_wready);
    wa = s_q.aw_got ? s_q.awaddr : 8'(s_axi_awaddr);
    wd = s_q.w_got ? s_q.wdata : s_axi_wdata;
    ws = s_q.w_got ? s_q.wstrb : s_axi_wstrb;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (have_aw && have_w && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `CSD_RESP_OKAY;
      case ({wa[7:2], 2'b00})
        `CSD_OFF_MASK: begin
          if (ws[0]) begin
            s_d.mask[7:0] = wd[7:0];
          end
          if (ws[1]) begin
            s_d.mask[15:8] = wd[15:8];
          end
        end
        `CSD_OFF_CLEAR: begin
          clr = ws[1] && wd[`CSD_MASK_ERR_BIT];
        end
        `CSD_OFF_STATUS, `CSD_OFF_COUNT, `CSD_OFF_DIAG,
        `CSD_OFF_PEND: begin
          s_d.bresp = `CSD_RESP_OKAY;
        end
        default: begin
          s_d.bresp = `CSD_RESP_SLVERR;
        end
      endcase
    end

    // Error pending: a set in the clearing cycle wins.
    s_d.fault_pend = chg || (s_q.fault_pend && !clr);

    // Read channel.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ra = 8'(s_axi_araddr);
      s_d.rvalid = 1'b1;
      s_d.rresp = `CSD_RESP_OKAY;
      case ({ra[7:2], 2'b00})
        `CSD_OFF_STATUS: s_d.rdata = {16'h0000, status_w};
        `CSD_OFF_COUNT: s_d.rdata = {16'h0000, count_w};
        `CSD_OFF_DIAG: s_d.rdata = {16'h0000, s_q.diag};
        `CSD_OFF_MASK: s_d.rdata = {16'h0000, s_q.mask};
        `CSD_OFF_PEND: s_d.rdata = {16'h0000, pend_w};
        `CSD_OFF_CLEAR: s_d.rdata = 32'h0000_0000;
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `CSD_RESP_SLVERR;
        end
      endcase
    end
  end

  // ========================================================
  // State register.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.mask <= `CSD_RST_MASK;
      s_q.diag <= `CSD_RST_REG16;
      s_q.receive_fault_count <= `CSD_RST_CNT;
      s_q.transmit_fault_count <= `CSD_RST_CNT;
      s_q.rx_s1 <= `CSD_RST_PIN;
      s_q.rx_s2 <= `CSD_RST_PIN;
      s_q.tx_pin <= `CSD_RST_PIN;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================
  // Assertions.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_status_reset;
    $rose(nrst) |-> status_w == `CSD_RST_REG16;
  endproperty
  a_status_reset: assert property (p_status_reset)
    else $error("Status register not zero after reset.");

  property p_busoff_code;
    s_d.bus_off && can_enable |=> s_q.ns[2:1] == 2'b11;
  endproperty
  a_busoff_code: assert property (p_busoff_code)
    else $error("Bus off not shown as node state 11x.");

  property p_err_first;
    s_q.fault_pend && s_q.mask[15] |-> status_w[4:0] == 5'h10;
  endproperty
  a_err_first: assert property (p_err_first)
    else $error("Error source did not take the interrupt code.");

  property p_no_request;
    (pend & s_q.mask) == 16'h0000 |-> status_w[4:0] == 5'h00;
  endproperty
  a_no_request: assert property (p_no_request)
    else $error("Interrupt code set with nothing enabled pending.");

  property p_tec_step;
    fc_ev.tx_err && !fc_ev.recover && !s_q.bus_off &&
        s_q.transmit_fault_count < 8'hF8 |=> s_q.transmit_fault_count == $past(s_q.transmit_fault_count) + 8'h08;
  endproperty
  a_tec_step: assert property (p_tec_step)
    else $error("Transmit error did not add eight.");

  property p_index_load;
    field_in.field_start ##1 (!field_in.field_start &&
        field_in.bit_tick) |=> s_q.bit_cnt ==
        6'($past(field_in.field_len, 2) - 7'h02);
  endproperty
  a_index_load: assert property (p_index_load)
    else $error("Bit index did not load and count down.");

  property p_txe_capture;
    err_ev.error |=> s_q.diag.was_transmitter_flag == $past(transmitting) &&
        s_q.diag.field == $past(s_q.field);
  endproperty
  a_txe_capture: assert property (p_txe_capture)
    else $error("Diagnosis did not capture role and field.");

  property p_receiver_quiet;
    !transmitting && !ack_slot && !active_err_flag |=>
        bus_transmit_pin == 1'b1;
  endproperty
  a_receiver_quiet: assert property (p_receiver_quiet)
    else $error("Receiver drove the bus outside its slots.");

  property p_pend_set;
    s_d.receive_fault_count != s_q.receive_fault_count |=> s_q.fault_pend [*2];
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("Counter change did not hold the pending flag.");

endmodule : csd_status_diag

// File: shared/csd_defs.svh
// Register map, field positions, reset values and thresholds of the
// status and diagnostic block.
// Assumes inclusion by the block itself.
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

// ==========================================================
// Register byte offsets.
`define CSD_OFF_STATUS 8'h00
`define CSD_OFF_COUNT 8'h04
`define CSD_OFF_DIAG 8'h08
`define CSD_OFF_MASK 8'h0C
`define CSD_OFF_PEND 8'h10
`define CSD_OFF_CLEAR 8'h14

// ==========================================================
// Field positions.
`define CSD_ST_NS_LSB 5
`define CSD_ST_IRQ_BIT 4
`define CSD_CNT_REC_LSB 8
`define CSD_MASK_ERR_BIT 15
`define CSD_DIAG_IDX_LSB 4

// ==========================================================
// Reset values.
`define CSD_RST_REG16 16'h0000
`define CSD_RST_MASK 16'h0000
`define CSD_RST_CNT 8'h00
`define CSD_RST_PIN 1'b1

// ==========================================================
// Fault confinement figures.
`define CSD_WARN_LIMIT 8'h60
`define CSD_PASSIVE_LIMIT 8'h80
`define CSD_REC_CAP 8'h7F
`define CSD_STEP_LIGHT 9'h001
`define CSD_STEP_HEAVY 9'h008
`define CSD_CNT_MAX 9'h0FF

// ==========================================================
// Bus answers.
`define CSD_RESP_OKAY 2'b00
`define CSD_RESP_SLVERR 2'b10

`endif

// File: shared/csd_pkg.sv
// Types of the status and diagnostic block.
// Assumes csd_defs.svh sits beside it on the include path.
package csd_pkg;

  // ========================================================
  // Node state codes.
  typedef enum logic [2:0] {
    CSD_NS_OFF = 3'b000,
    CSD_NS_ACTIVE = 3'b010,
    CSD_NS_WARN = 3'b011,
    CSD_NS_PASSIVE = 3'b100,
    CSD_NS_BUSOFF = 3'b110
  } csd_ns_t;

  // ========================================================
  // Fault confinement events from the bit stream engine.
  typedef struct packed {
    logic rx_err;
    logic rx_err_heavy;
    logic rx_ok;
    logic tx_err;
    logic tx_ok;
    logic recover;
  } csd_fc_ev_t;

  // ========================================================
  // Bus error report from the bit stream engine.
  typedef struct packed {
    logic error;
    logic stuff;
    logic crc;
  } csd_err_ev_t;

  // ========================================================
  // Frame field progress from the bit stream engine.
  typedef struct packed {
    logic field_start;
    logic [3:0] field_code;
    logic [6:0] field_len;
    logic bit_tick;
  } csd_field_t;

  // ========================================================
  // Last error diagnosis, laid out as read.
  typedef struct packed {
    logic rsvd;
    logic drive;
    logic mon;
    logic crc;
    logic stuff;
    logic was_transmitter_flag;
    logic [5:0] bit_index;
    logic [3:0] field;
  } csd_diag_t;

  // ========================================================
  // Whole state of the block.
  typedef struct packed {
    logic [7:0] receive_fault_count;
    logic [7:0] transmit_fault_count;
    logic bus_off;
    logic [2:0] ns;
    logic fault_pend;
    logic [15:0] mask;
    csd_diag_t diag;
    logic [5:0] bit_cnt;
    logic [3:0] field;
    logic rx_s1;
    logic rx_s2;
    logic tx_pin;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csd_state_t;

endpackage : csd_pkg

// File: sim/csd_can_bus_model.sv
// CAN bus behind a transceiver, seen from the controller's pins.
// Assumes one other node that may pull the wire dominant on command.
`timescale 1ns/1ps

module csd_can_bus_model (
  // Controller side.
  input wire logic bus_transmit_pin,
  output logic bus_receive_pin,
  // Other node.
  input wire logic peer_dominant
);
  // ========================================================
  // Wired-AND bus: dominant low wins, idle wire is recessive.
  assign bus_receive_pin = bus_transmit_pin & ~peer_dominant;
endmodule : csd_can_bus_model

// File: sim/csd_status_diag_tb_top.sv
// Self-checking bench of the status and diagnostic block.
// Assumes the design package, defines header and the bus model.
`timescale 1ns/1ps

module csd_status_diag_tb_top;
  import csd_pkg::*;
  // ========================================================
  // Signals.
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, arready, bvalid, rvalid;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic can_enable = 1'b0;
  logic [14:0] pend = 15'h0000;
  csd_fc_ev_t fc_ev = '0;
  csd_err_ev_t err_ev = '0;
  csd_field_t field_in = '0;
  logic transmitting = 1'b0, ack_slot = 1'b0, active_err_flag = 1'b0;
  logic tx_bit = 1'b1, peer_dominant = 1'b0, tx_pin, rx_pin;
  logic [31:0] seed = 32'h0000_c0bb;
  logic [15:0] mask;
  logic [6:0] len;
  logic [5:0] k;
  logic pin;
  int bad_count = 0, cmp_count = 0, cyc = 0;

  always #2.5 clock = ~clock;

  csd_status_diag dut_u (.clock(clock), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .can_enable(can_enable),
    .buffer_pending_flags(pend), .fc_ev(fc_ev), .err_ev(err_ev),
    .field_in(field_in), .transmitting(transmitting),
    .ack_slot(ack_slot), .active_err_flag(active_err_flag),
    .tx_bit(tx_bit), .bus_receive_pin(rx_pin),
    .bus_transmit_pin(tx_pin));

  csd_can_bus_model bus_u (.bus_transmit_pin(tx_pin),
    .bus_receive_pin(rx_pin), .peer_dominant(peer_dominant));

  // ========================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [4:0] irq_exp(input logic [15:0] m,
      input logic fp, input logic [14:0] p);
    if (fp && m[15]) return 5'h10;
    for (int n = 0; n < 15; n++) if (p[n] && m[n]) return 5'(17 + n);
    return 5'h00;
  endfunction : irq_exp

  function automatic logic [2:0] ns_exp(input logic en, input logic bo,
      input logic [7:0] r, input logic [7:0] t);
    if (!en) return 3'b000;
    if (bo) return 3'b110;
    if (r >= 8'h80 || t >= 8'h80) return 3'b100;
    if (r >= 8'h60 || t >= 8'h60) return 3'b011;
    return 3'b010;
  endfunction : ns_exp

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, done;
    ta = 1'b0;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      resp = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : axi_wr

  task automatic rd_chk(input string nm, input logic [7:0] a,
      input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    logic ta, done;
    logic [31:0] got;
    logic [1:0] gr;
    done = 1'b0;
    got = 32'h0000_0000;
    gr = 2'b00;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(negedge clock);
      ta = arvalid && arready;
      done = rvalid;
      if (rvalid) begin
        got = rdata;
        gr = rresp;
      end
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
    end
    chk(nm, e & m, got & m);
    chk({nm, " resp"}, {30'h0, er}, {30'h0, gr});
  endtask : rd_chk

  task automatic fc_pulse(input logic [5:0] e);
    fc_ev <= csd_fc_ev_t'(e);
    @(posedge clock);
    fc_ev <= '0;
    @(posedge clock);
  endtask : fc_pulse

  always @(posedge clock) begin
    cyc++;
    if (cyc > 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ========================================================
  // Tests.
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd_chk("status", 8'h00, 0, 32'hffff_ffff, 2'b00);
    rd_chk("counters", 8'h04, 0, 32'hffff_ffff, 2'b00);
    rd_chk("diag", 8'h08, 0, 32'hffff_ffff, 2'b00);
    rd_chk("unmapped", 8'h18, 0, 32'hffff_ffff, 2'b10);
    axi_wr(8'h08, 32'h0000_ffff);
    chk("bresp ro", 32'h0000_0000, {30'h0, resp});
    rd_chk("diag ro", 8'h08, 0, 32'hffff_ffff, 2'b00);
    axi_wr(8'h18, 32'h0000_0001);
    chk("bresp unmapped", 32'h0000_0002, {30'h0, resp});
    can_enable <= 1'b1;
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      mask = (i == 0) ? 16'hffff : seed[15:0];
      pend <= (i == 0) ? 15'h4000 : (i == 1) ? 15'h0000 : seed[30:16];
      axi_wr(8'h0c, {16'h0000, mask});
      rd_chk("mask", 8'h0c, {16'h0000, mask}, 32'hffff_ffff, 2'b00);
      rd_chk("irq", 8'h00, {27'h2, irq_exp(mask, 1'b0, pend)},
        32'hffff_ffff, 2'b00);
      rd_chk("pend", 8'h10, {17'h0, pend}, 32'hffff_ffff, 2'b00);
    end
    pend <= 15'h0000;
    $display("test irq code done");
    axi_wr(8'h0c, 32'h0000_8000);
    fc_pulse(6'b100000);
    rd_chk("rec", 8'h04, 32'h0000_0100, 32'hffff_ffff, 2'b00);
    rd_chk("fault irq", 8'h00, 32'h0000_0050, 32'hffff_ffff,
      2'b00);
    rd_chk("pend flag", 8'h10, 32'h0000_8000, 32'hffff_ffff, 2'b00);
    axi_wr(8'h14, 32'h0000_8000);
    rd_chk("cleared", 8'h00, 32'h0000_0040, 32'hffff_ffff, 2'b00);
    fc_pulse(6'b001000);
    for (int i = 1; i <= 32; i++) begin
      fc_pulse(6'b000100);
      if (i == 1 || i == 12 || i == 16 || i == 32) begin
        rd_chk("tec", 8'h04, (i == 32) ? 255 : i * 8, 32'hffff_ffff,
          2'b00);
        rd_chk("state", 8'h00, {24'h0, ns_exp(1'b1, i == 32, 8'h00,
          (i == 32) ? 8'hff : 8'(i * 8)), 5'h10},
          (i >= 16) ? 32'hc0 : 32'he0, 2'b00);
      end
    end
    can_enable <= 1'b0;
    @(posedge clock);
    rd_chk("off", 8'h00, 0, 32'he0, 2'b00);
    fc_pulse(6'b000001);
    can_enable <= 1'b1;
    @(posedge clock);
    rd_chk("recover", 8'h04, 0, 32'hffff_ffff, 2'b00);
    rd_chk("active", 8'h00, 32'h40, 32'he0, 2'b00);
    $display("test counters done");
    for (int c = 0; c < 16; c++) begin
      seed = lfsr(seed);
      len = 7'(seed[5:0]) + 7'd1;
      k = 6'(seed[13:8] % len);
      field_in <= '{1'b1, 4'(c), len, 1'b0};
      {transmitting, ack_slot, active_err_flag} <= seed[18:16];
      tx_bit <= seed[19];
      peer_dominant <= seed[20];
      @(posedge clock);
      field_in.field_start <= 1'b0;
      for (int t = 0; t < k; t++) begin
        field_in.bit_tick <= 1'b1;
        @(posedge clock);
        field_in.bit_tick <= 1'b0;
        @(posedge clock);
      end
      repeat (4) @(posedge clock);
      pin = (seed[18] | seed[17] | seed[16]) ? seed[19] : 1'b1;
      chk("pin", {31'h0, pin}, {31'h0, tx_pin});
      err_ev <= '{1'b1, seed[21], seed[22]};
      @(posedge clock);
      err_ev <= '0;
      @(posedge clock);
      rd_chk("diag", 8'h08, {17'h0, pin, pin & ~seed[20], seed[22],
        seed[21], seed[18], 6'(len - 7'd1 - 7'(k)), 4'(c)},
        32'hffff_ffff, 2'b00);
    end
    $display("test diagnosis done");
    fc_pulse(6'b010000);
    rd_chk("heavy", 8'h04, 32'h0000_0800, 32'hffff_ffff, 2'b00);
    axi_wr(8'h0c, 32'h0000_a5c3);
    wstrb <= 4'h1;
    axi_wr(8'h0c, 32'h0000_ff3c);
    wstrb <= 4'hf;
    rd_chk("mask strobe", 8'h0c, 32'h0000_a53c, 32'hffff_ffff,
      2'b00);
    can_enable <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd_chk("status rst", 8'h00, 0, 32'hffff_ffff, 2'b00);
    rd_chk("counters rst", 8'h04, 0, 32'hffff_ffff, 2'b00);
    rd_chk("diag rst", 8'h08, 0, 32'hffff_ffff, 2'b00);
    rd_chk("mask rst", 8'h0c, 0, 32'hffff_ffff, 2'b00);
    $display("test reset again done");
    print_verdict();
  end
endmodule : csd_status_diag_tb_top
